// ==== rtl/cdp_map.svh ====
`ifndef CDP_MAP_SVH
`define CDP_MAP_SVH

// ----------------------------------------------------------------------
// register indices and bus addresses
// ----------------------------------------------------------------------
`define CDP_IDX_PTR_LOW 8'h82
`define CDP_IDX_PTR_HIGH 8'h83
`define CDP_IDX_AUX_CTRL 8'hA2
`define CDP_IDX_FLAG_STAT 8'hC0
`define CDP_ADDR_W 12
`define CDP_ADDR_PTR_LOW 12'h208
`define CDP_ADDR_PTR_HIGH 12'h20C
`define CDP_ADDR_AUX_CTRL 12'h288
`define CDP_ADDR_FLAG_STAT 12'h300

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define CDP_RST_BYTE 8'h00
`define CDP_RST_WORD 16'h0000
`define CDP_AUX_SEL_BIT 0
`define CDP_AUX_ZERO_BIT 1
`define CDP_AUX_FLAG2_BIT 3
`define CDP_AUX_RW_MASK 8'hFD
`define CDP_STAT_CARRY_BIT 7
`define CDP_STAT_AUX_CARRY_BIT 6
`define CDP_STAT_OVERFLOW_BIT 2
`define CDP_RESP_OKAY 2'h0
`define CDP_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// opcodes and opcode groups
// ----------------------------------------------------------------------
`define CDP_OP_INC_PTR 8'hA3
`define CDP_OP_LOAD_PTR 8'h90
`define CDP_OP_MOVX_RD 8'hE0
`define CDP_OP_MOVX_WR 8'hF0
`define CDP_OP_CODE_RD 8'h93
`define CDP_OP_LONG_JUMP 8'h02
`define CDP_OP_LONG_CALL 8'h12
`define CDP_OP_SHORT_JUMP 8'h80
`define CDP_OP_MUL 8'hA4
`define CDP_OP_DIV 8'h84
`define CDP_OP_DA 8'hD4
`define CDP_OP_RRC 8'h13
`define CDP_OP_RLC 8'h33
`define CDP_OP_CLR_C 8'hC3
`define CDP_OP_SET_C 8'hD3
`define CDP_OP_CPL_C 8'hB3
`define CDP_OP_ANL_C 8'h82
`define CDP_OP_ANL_NC 8'hB0
`define CDP_OP_ORL_C 8'h72
`define CDP_OP_ORL_NC 8'hA0
`define CDP_OP_MOV_C 8'hA2
`define CDP_OP_CJNE_A_IMM 8'hB4
`define CDP_OP_CJNE_A_DIR 8'hB5
`define CDP_ROW_ADD 4'h2
`define CDP_ROW_ADDC 4'h3
`define CDP_ROW_SUBB 4'h9
`define CDP_ROW_CJNE 4'hB
`define CDP_COL_ARITH 4'h4
`define CDP_COL_DIRECT 4'h5
`define CDP_COL_JUMP_PAGE 4'h1
`define CDP_SFR_BASE 8'h80
`define CDP_BIT_RAM_BASE 4'h2
`define CDP_BCD_LIMIT 4'h9
`define CDP_BCD_ADJ_LO 8'h06
`define CDP_BCD_ADJ_HI 9'h060
`define CDP_PAGE_HI 15
`define CDP_PAGE_LO 11

`endif

// ==== rtl/cdp_pkg.sv ====
`default_nettype none

package cdp_pkg;

  typedef enum logic [1:0] {
    CDP_SP_NONE,
    CDP_SP_IRAM,
    CDP_SP_SFR,
    CDP_SP_BIT
  } cdp_space_type;

  // one decoded instruction offered by the fetch stage
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [15:0] next_pc;
  } cdp_instr_type;

  // operand values read by the core for this instruction
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] breg;
    logic [7:0] opnd;
    logic [7:0] ri_val;
    logic [1:0] bank;
    logic bit_val;
  } cdp_src_type;

  typedef struct packed {
    logic valid;
    logic [1:0] length;
    cdp_space_type space;
    logic indirect;
    logic [7:0] addr;
    logic [2:0] bit_idx;
    logic [15:0] ext_addr;
    logic ext_valid;
    logic [15:0] target;
    logic target_valid;
    logic carry;
    logic overflow;
    logic aux_carry;
  } cdp_result_type;

endpackage

`default_nettype wire

// ==== rtl/cdp_core.sv ====
// Summary of operation
// - low pointer byte, read/write, resets zero
// - high pointer byte, read/write, resets zero
// - active pointer addresses external and code reads
// - select bit zero picks pointer zero
// - bit three is a free user flag
// - bit one reads zero, increment leaves select unchanged
// - standard instruction results, own timing
// - one clock per machine cycle, overlapped
// - opcode byte plus zero to two operands
// - add/subtract set carry, overflow, aux carry
// - carry-only instructions update carry as defined
// - register operands map to current bank
// - direct below 80H is RAM, else SFR
// - indirect through R0/R1 reaches 00H-FFH
// - immediates are 8-bit, pointer load 16-bit
// - long jump/call carry full 16-bit target
// - absolute target stays in 2K page
// - relative offset signed, from next instruction
// - bit operands in RAM or SFR space
`include "cdp_map.svh"
`default_nettype none

module cdp_core (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire cdp_pkg::cdp_instr_type i_instr,
  input wire cdp_pkg::cdp_src_type i_src,
  output cdp_pkg::cdp_result_type o_result,
  input wire logic [`CDP_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [`CDP_ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [15:0] ptr_zero_reg;
  logic [15:0] ptr_one_reg;
  logic [7:0] aux_reg;
  logic carry_reg;
  logic ovf_reg;
  logic ac_reg;
  logic [`CDP_ADDR_W-1:0] aw_addr_reg;
  logic aw_full_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic w_full_reg;
  cdp_pkg::cdp_result_type result_next;
  logic carry_next;
  logic ovf_next;
  logic ac_next;
  logic [15:0] ptr_next;
  logic ptr_load;

  logic sel;
  logic [15:0] act_ptr;
  logic [7:0] op;
  logic [3:0] row;
  logic [3:0] col;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign sel = aux_reg[`CDP_AUX_SEL_BIT];
  assign act_ptr = sel ? ptr_one_reg : ptr_zero_reg;
  assign op = i_instr.opcode;
  assign row = op[7:4];
  assign col = op[3:0];
  assign wr_fire = aw_full_reg && w_full_reg && !o_s_axi_bvalid;
  assign rd_fire = i_s_axi_arvalid && o_s_axi_arready;

  // --------------------------------------------------------------------
  // instruction length
  // --------------------------------------------------------------------
  // one to three bytes
  function automatic logic [1:0] instr_len(input logic [7:0] opc);
    logic [1:0] len;
    len = 2'h1;
    if (opc[3:0] == `CDP_COL_JUMP_PAGE) begin
      len = 2'h2;
    end
    case (opc)
      8'h02, 8'h10, 8'h12, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75,
      8'h85, 8'h90, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA,
      8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hD5: begin
        len = 2'h3;
      end
      8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h40, 8'h42, 8'h44,
      8'h45, 8'h50, 8'h52, 8'h54, 8'h55, 8'h60, 8'h62, 8'h64, 8'h65,
      8'h70, 8'h72, 8'h74, 8'h76, 8'h77, 8'h80, 8'h82, 8'h86, 8'h87,
      8'h92, 8'h94, 8'h95, 8'hA0, 8'hA2, 8'hA6, 8'hA7, 8'hB0, 8'hB2,
      8'hC0, 8'hC2, 8'hC5, 8'hD0, 8'hD2, 8'hE5, 8'hF5: begin
        len = 2'h2;
      end
      default: begin
        if (opc[3] && (opc[7:4] == 4'h7 || opc[7:4] == 4'h8 ||
            opc[7:4] == 4'hA || opc[7:4] == 4'hD)) begin
          len = 2'h2;
        end
      end
    endcase
    return len;
  endfunction

  // --------------------------------------------------------------------
  // decode and flag evaluation
  // --------------------------------------------------------------------
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic cin;
    logic [15:0] prod;
    logic [8:0] adj;
    logic is_bit;
    result_next = '0;
    carry_next = carry_reg;
    ovf_next = ovf_reg;
    ac_next = ac_reg;
    ptr_load = 1'b0;
    ptr_next = act_ptr;
    sum = '0;
    nib = '0;
    cin = 1'b0;
    prod = '0;
    adj = '0;
    is_bit = 1'b0;
    result_next.valid = i_instr.valid;
    result_next.length = instr_len(op);
    case (op)
      8'h10, 8'h20, 8'h30, 8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2,
      8'hB0, 8'hB2, 8'hC2, 8'hD2: begin
        is_bit = 1'b1;
      end
      default: begin
        is_bit = 1'b0;
      end
    endcase
    if (is_bit) begin
      result_next.space = cdp_pkg::CDP_SP_BIT;
      result_next.bit_idx = i_instr.byte1[2:0];
      if (i_instr.byte1 < `CDP_SFR_BASE) begin
        result_next.addr = {`CDP_BIT_RAM_BASE, i_instr.byte1[6:3]};
      end else begin
        result_next.addr = {i_instr.byte1[7:3], 3'h0};
      end
    end else if (col[3]) begin
      result_next.space = cdp_pkg::CDP_SP_IRAM;
      result_next.addr = {3'h0, i_src.bank, op[2:0]};
    end else if (col[3:1] == 3'h3) begin
      result_next.space = cdp_pkg::CDP_SP_IRAM;
      result_next.indirect = 1'b1;
      result_next.addr = i_src.ri_val;
    end else if (col == `CDP_COL_DIRECT ||
        (col[3:1] == 3'h1 && row >= 4'h4 && row <= 4'h6)) begin
      result_next.addr = i_instr.byte1;
      result_next.space = (i_instr.byte1 < `CDP_SFR_BASE) ?
          cdp_pkg::CDP_SP_IRAM : cdp_pkg::CDP_SP_SFR;
    end

    if (op == `CDP_OP_MOVX_RD || op == `CDP_OP_MOVX_WR) begin
      result_next.ext_valid = 1'b1;
      result_next.ext_addr = act_ptr;
    end else if (op == `CDP_OP_CODE_RD) begin
      result_next.ext_valid = 1'b1;
      result_next.ext_addr = act_ptr + {8'h00, i_src.acc};
    end

    if (op == `CDP_OP_LONG_JUMP || op == `CDP_OP_LONG_CALL) begin
      result_next.target_valid = 1'b1;
      result_next.target = {i_instr.byte1, i_instr.byte2};
    end else if (col == `CDP_COL_JUMP_PAGE) begin
      result_next.target_valid = 1'b1;
      result_next.target = {i_instr.next_pc[`CDP_PAGE_HI:`CDP_PAGE_LO],
                            op[7:5], i_instr.byte1};
    end else if (op == `CDP_OP_SHORT_JUMP) begin
      result_next.target_valid = 1'b1;
      result_next.target = i_instr.next_pc +
                           {{8{i_instr.byte1[7]}}, i_instr.byte1};
    end else if ((col == 4'h0 && row != 4'h0 && row <= 4'h7) ||
        op == 8'hD5 ||
        (row == `CDP_ROW_CJNE && col >= `CDP_COL_ARITH) ||
        (row == 4'hD && col[3])) begin
      result_next.target_valid = 1'b1;
      if (instr_len(op) == 2'h3) begin
        result_next.target = i_instr.next_pc +
                             {{8{i_instr.byte2[7]}}, i_instr.byte2};
      end else begin
        result_next.target = i_instr.next_pc +
                             {{8{i_instr.byte1[7]}}, i_instr.byte1};
      end
    end

    if (op == `CDP_OP_LOAD_PTR) begin
      ptr_load = 1'b1;
      ptr_next = {i_instr.byte1, i_instr.byte2};
    end else if (op == `CDP_OP_INC_PTR) begin
      ptr_load = 1'b1;
      ptr_next = act_ptr + 16'h0001;
    end

    if ((row == `CDP_ROW_ADD || row == `CDP_ROW_ADDC) &&
        col >= `CDP_COL_ARITH) begin
      cin = (row == `CDP_ROW_ADDC) ? carry_reg : 1'b0;
      sum = {1'b0, i_src.acc} + {1'b0, i_src.opnd} + {8'h00, cin};
      nib = {1'b0, i_src.acc[3:0]} + {1'b0, i_src.opnd[3:0]} + {4'h0, cin};
      carry_next = sum[8];
      ac_next = nib[4];
      ovf_next = (i_src.acc[7] == i_src.opnd[7]) &&
                 (sum[7] != i_src.acc[7]);
    end else if (row == `CDP_ROW_SUBB && col >= `CDP_COL_ARITH) begin
      sum = {1'b0, i_src.acc} - {1'b0, i_src.opnd} - {8'h00, carry_reg};
      nib = {1'b0, i_src.acc[3:0]} - {1'b0, i_src.opnd[3:0]} -
            {4'h0, carry_reg};
      carry_next = sum[8];
      ac_next = nib[4];
      ovf_next = (i_src.acc[7] != i_src.opnd[7]) &&
                 (sum[7] != i_src.acc[7]);
    end else if (op == `CDP_OP_MUL) begin
      prod = i_src.acc * i_src.breg;
      carry_next = 1'b0;
      ovf_next = (prod[15:8] != 8'h00);
    end else if (op == `CDP_OP_DIV) begin
      carry_next = 1'b0;
      ovf_next = (i_src.breg == 8'h00);
    end else begin
      case (op)
        `CDP_OP_DA: begin
          adj = {1'b0, i_src.acc};
          if (adj[3:0] > `CDP_BCD_LIMIT || ac_reg) begin
            adj = adj + {1'b0, `CDP_BCD_ADJ_LO};
          end
          if (adj[7:4] > `CDP_BCD_LIMIT || adj[8] || carry_reg) begin
            adj = adj + `CDP_BCD_ADJ_HI;
          end
          carry_next = carry_reg | adj[8];
        end
        `CDP_OP_RRC: carry_next = i_src.acc[0];
        `CDP_OP_RLC: carry_next = i_src.acc[7];
        `CDP_OP_CLR_C: carry_next = 1'b0;
        `CDP_OP_SET_C: carry_next = 1'b1;
        `CDP_OP_CPL_C: carry_next = !carry_reg;
        `CDP_OP_ANL_C: carry_next = carry_reg & i_src.bit_val;
        `CDP_OP_ANL_NC: carry_next = carry_reg & !i_src.bit_val;
        `CDP_OP_ORL_C: carry_next = carry_reg | i_src.bit_val;
        `CDP_OP_ORL_NC: carry_next = carry_reg | !i_src.bit_val;
        `CDP_OP_MOV_C: carry_next = i_src.bit_val;
        `CDP_OP_CJNE_A_IMM: carry_next = i_src.acc < i_instr.byte1;
        `CDP_OP_CJNE_A_DIR: carry_next = i_src.acc < i_src.opnd;
        default: begin
          if (row == `CDP_ROW_CJNE && col[3:1] >= 3'h3) begin
            carry_next = i_src.opnd < i_instr.byte1;
          end
        end
      endcase
    end
    result_next.carry = carry_next;
    result_next.overflow = ovf_next;
    result_next.aux_carry = ac_next;
    if (!i_instr.valid) begin
      result_next = '0;
      carry_next = carry_reg;
      ovf_next = ovf_reg;
      ac_next = ac_reg;
      ptr_load = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // result and flags
  // --------------------------------------------------------------------
  // registered result each cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_result <= '0;
      carry_reg <= 1'b0;
      ovf_reg <= 1'b0;
      ac_reg <= 1'b0;
    end else begin
      o_result <= result_next;
      carry_reg <= carry_next;
      ovf_reg <= ovf_next;
      ac_reg <= ac_next;
    end
  end

  // --------------------------------------------------------------------
  // pointers
  // --------------------------------------------------------------------
  // pointer zero and pointer one registers, both bytes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ptr_zero_reg <= `CDP_RST_WORD;
      ptr_one_reg <= `CDP_RST_WORD;
    end else begin
      if (ptr_load && !sel) begin
        ptr_zero_reg <= ptr_next;
      end
      if (ptr_load && sel) begin
        ptr_one_reg <= ptr_next;
      end
      if (wr_fire && w_lane_reg && aw_addr_reg == `CDP_ADDR_PTR_LOW) begin
        if (sel) begin
          ptr_one_reg[7:0] <= w_data_reg;
        end else begin
          ptr_zero_reg[7:0] <= w_data_reg;
        end
      end
      if (wr_fire && w_lane_reg && aw_addr_reg == `CDP_ADDR_PTR_HIGH) begin
        if (sel) begin
          ptr_one_reg[15:8] <= w_data_reg;
        end else begin
          ptr_zero_reg[15:8] <= w_data_reg;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aux_reg <= `CDP_RST_BYTE;
    end else if (wr_fire && w_lane_reg &&
        aw_addr_reg == `CDP_ADDR_AUX_CTRL) begin
      aux_reg <= w_data_reg & `CDP_AUX_RW_MASK;
    end
  end

  // --------------------------------------------------------------------
  // bus write channel
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_addr_reg <= '0;
      aw_full_reg <= 1'b0;
      o_s_axi_awready <= 1'b0;
    end else begin
      o_s_axi_awready <= !aw_full_reg && !o_s_axi_awready;
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_addr_reg <= {i_s_axi_awaddr[`CDP_ADDR_W-1:2], 2'h0};
        aw_full_reg <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      w_data_reg <= `CDP_RST_BYTE;
      w_lane_reg <= 1'b0;
      w_full_reg <= 1'b0;
      o_s_axi_wready <= 1'b0;
    end else begin
      o_s_axi_wready <= !w_full_reg && !o_s_axi_wready;
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_data_reg <= i_s_axi_wdata[7:0];
        w_lane_reg <= i_s_axi_wstrb[0];
        w_full_reg <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `CDP_RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      case (aw_addr_reg)
        `CDP_ADDR_PTR_LOW, `CDP_ADDR_PTR_HIGH, `CDP_ADDR_AUX_CTRL,
        `CDP_ADDR_FLAG_STAT: o_s_axi_bresp <= `CDP_RESP_OKAY;
        default: o_s_axi_bresp <= `CDP_RESP_SLVERR;
      endcase
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // bus read channel
  // --------------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    case ({i_s_axi_araddr[`CDP_ADDR_W-1:2], 2'h0})
      `CDP_ADDR_PTR_LOW: rd_byte = act_ptr[7:0];
      `CDP_ADDR_PTR_HIGH: rd_byte = act_ptr[15:8];
      `CDP_ADDR_AUX_CTRL: rd_byte = aux_reg;
      `CDP_ADDR_FLAG_STAT: begin
        rd_byte = `CDP_RST_BYTE;
        rd_byte[`CDP_STAT_CARRY_BIT] = carry_reg;
        rd_byte[`CDP_STAT_AUX_CARRY_BIT] = ac_reg;
        rd_byte[`CDP_STAT_OVERFLOW_BIT] = ovf_reg;
      end
      default: begin
        rd_byte = `CDP_RST_BYTE;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= `CDP_RESP_OKAY;
    end else begin
      o_s_axi_arready <= !o_s_axi_rvalid && !o_s_axi_arready;
      if (rd_fire) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= {24'h000000, rd_byte};
        o_s_axi_rresp <= rd_hit ? `CDP_RESP_OKAY : `CDP_RESP_SLVERR;
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ==== tb/cdp_core_asserts.sv ====
`include "cdp_map.svh"
`default_nettype none

module cdp_core_asserts (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire cdp_pkg::cdp_instr_type i_instr,
  input wire cdp_pkg::cdp_src_type i_src,
  input wire cdp_pkg::cdp_result_type o_result
);
  cdp_pkg::cdp_instr_type iq;
  cdp_pkg::cdp_src_type sq;
  logic [7:0] op;
  logic [8:0] sum_full;
  logic [4:0] sum_half;
  logic [15:0] product;

  // ------------------------------------------------------------------
  // operands of the instruction now being answered
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      iq <= '0;
      sq <= '0;
    end else begin
      iq <= i_instr;
      sq <= i_src;
    end
  end
  // idle cycles look like a no-op
  assign op = i_instr.valid ? i_instr.opcode : 8'h00;
  assign sum_full = {1'b0, sq.acc} + {1'b0, sq.opnd};
  assign sum_half = {1'b0, sq.acc[3:0]} + {1'b0, sq.opnd[3:0]};
  assign product = {8'h00, sq.acc} * {8'h00, sq.breg};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_valid; i_instr.valid |=> o_result.valid; endproperty
  a_valid: assert property (p_valid)
    else $error("instruction not answered next cycle");
  property p_ext; op == `CDP_OP_MOVX_RD |=> o_result.ext_valid; endproperty
  a_ext: assert property (p_ext)
    else $error("external access without pointer address");
  property p_long;
    op == `CDP_OP_LONG_JUMP |=> o_result.target_valid
      && o_result.length == 2'h3
      && o_result.target == {iq.byte1, iq.byte2};
  endproperty
  a_long: assert property (p_long)
    else $error("long target wrong");
  property p_short;
    op == `CDP_OP_SHORT_JUMP |=>
      o_result.target == iq.next_pc + {{8{iq.byte1[7]}}, iq.byte1};
  endproperty
  a_short: assert property (p_short)
    else $error("relative target wrong");
  property p_cond;
    op[3:0] == 4'h0 && op[7:4] != 4'h0 && op[7:4] <= 4'h7 |=>
      o_result.target_valid;
  endproperty
  a_cond: assert property (p_cond)
    else $error("conditional branch without target");
  property p_page;
    op[4:0] == 5'h01 |=> o_result.target ==
      {iq.next_pc[15:11], iq.opcode[7:5], iq.byte1};
  endproperty
  a_page: assert property (p_page)
    else $error("page target wrong");
  property p_clr; op == `CDP_OP_CLR_C |=> !o_result.carry; endproperty
  a_clr: assert property (p_clr)
    else $error("carry not cleared");
  property p_set; op == `CDP_OP_SET_C |=> o_result.carry; endproperty
  a_set: assert property (p_set)
    else $error("carry not set");
  property p_mul;
    op == `CDP_OP_MUL |=> !o_result.carry
      && o_result.overflow == (product[15:8] != 8'h00);
  endproperty
  a_mul: assert property (p_mul)
    else $error("multiply flags wrong");
  property p_add;
    op == 8'h24 |=> o_result.carry == sum_full[8]
      && o_result.aux_carry == sum_half[4] && o_result.overflow ==
      (sq.acc[7] == sq.opnd[7] && sum_full[7] != sq.acc[7]);
  endproperty
  a_add: assert property (p_add)
    else $error("add flags wrong");
  property p_dir;
    op == 8'h25 |=> o_result.addr == iq.byte1 && o_result.space ==
      (iq.byte1[7] ? cdp_pkg::CDP_SP_SFR : cdp_pkg::CDP_SP_IRAM);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direct operand space wrong");
  property p_reg;
    op[7:3] == 5'h05 |=> o_result.addr == {3'h0, sq.bank, iq.opcode[2:0]};
  endproperty
  a_reg: assert property (p_reg)
    else $error("register operand address wrong");
  property p_ind;
    op[7:1] == 7'h13 |=> o_result.indirect && o_result.addr == sq.ri_val;
  endproperty
  a_ind: assert property (p_ind)
    else $error("indirect operand address wrong");
endmodule

bind cdp_core cdp_core_asserts u_chk (.i_clk, .i_reset_n, .i_instr, .i_src,
  .o_result);

`default_nettype wire

// ==== tb/test_cdp_core.sv ====
`include "cdp_map.svh"
`default_nettype none

module test_cdp_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  cdp_pkg::cdp_instr_type i_instr = '0;
  cdp_pkg::cdp_src_type i_src = '{8'h00, 8'h10, 8'h00, 8'hC5, 2'h2, 1'b0};
  cdp_pkg::cdp_result_type o_result;
  logic [11:0] i_s_axi_awaddr = '0;
  logic [11:0] i_s_axi_araddr = '0;
  logic [31:0] i_s_axi_wdata = '0;
  logic [3:0] i_s_axi_wstrb = '0;
  logic i_s_axi_awvalid = 1'b0;
  logic i_s_axi_wvalid = 1'b0;
  logic i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0;
  logic i_s_axi_rready = 1'b0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata, rd_data;
  int n_fail = 0;
  int n_checks = 0;

  cdp_core DUT (.i_clk, .i_reset_n, .i_instr, .i_src, .o_result,
    .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
    .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready);

  always #10 i_clk = ~i_clk;

  // ------------------------------------------------------------------
  // bus, instruction and compare tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= {24'h000000, d};
    i_s_axi_wstrb <= 4'hF;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (!o_s_axi_bvalid);
    chk({30'h0, o_s_axi_bresp}, {30'h0, `CDP_RESP_OKAY});
    i_s_axi_bready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                      input logic [1:0] resp);
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (!o_s_axi_rvalid);
    rd_data = o_s_axi_rdata;
    chk({30'h0, o_s_axi_rresp}, {30'h0, resp});
    i_s_axi_rready <= 1'b0;
    chk(rd_data, exp);
  endtask

  task automatic ex(input logic [7:0] op, input logic [7:0] b1,
                    input logic [15:0] pc, input logic [7:0] a);
    @(posedge i_clk);
    i_instr <= '{1'b1, op, b1, 8'h00, pc};
    i_src.acc <= a;
    i_src.opnd <= b1;
    @(posedge i_clk);
    i_instr.valid <= 1'b0;
    #1;
  endtask

  initial begin
    #200000;
    n_fail++;
    complete_run;
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    rchk(`CDP_ADDR_PTR_LOW, 32'h0, `CDP_RESP_OKAY);
    rchk(`CDP_ADDR_PTR_HIGH, 32'h0, `CDP_RESP_OKAY);
    rchk(`CDP_ADDR_AUX_CTRL, 32'h0, `CDP_RESP_OKAY);
    wr(`CDP_ADDR_PTR_LOW, 8'h34);
    wr(`CDP_ADDR_PTR_HIGH, 8'h12);
    rchk(`CDP_ADDR_PTR_LOW, 32'h34, `CDP_RESP_OKAY);
    rchk(`CDP_ADDR_PTR_HIGH, 32'h12, `CDP_RESP_OKAY);
    ex(`CDP_OP_MOVX_RD, 8'h00, 16'h0100, 8'h00);
    chk(o_result.ext_addr, 32'h1234);
    wr(`CDP_ADDR_AUX_CTRL, 8'h01);
    rchk(`CDP_ADDR_PTR_LOW, 32'h0, `CDP_RESP_OKAY);
    wr(`CDP_ADDR_PTR_LOW, 8'hFF);
    wr(`CDP_ADDR_PTR_HIGH, 8'hFF);
    ex(`CDP_OP_INC_PTR, 8'h00, 16'h0101, 8'h00);
    ex(`CDP_OP_CODE_RD, 8'h00, 16'h0102, 8'h00);
    chk(o_result.ext_addr, 32'h0000);
    wr(`CDP_ADDR_AUX_CTRL, 8'h00);
    ex(`CDP_OP_MOVX_WR, 8'h00, 16'h0103, 8'h00);
    chk(o_result.ext_addr, 32'h1234);
    wr(`CDP_ADDR_AUX_CTRL, 8'hFF);
    rchk(`CDP_ADDR_AUX_CTRL, 32'hFD, `CDP_RESP_OKAY);
    wr(`CDP_ADDR_AUX_CTRL, 8'h08);
    rchk(`CDP_ADDR_AUX_CTRL, 32'h08, `CDP_RESP_OKAY);
    rchk(12'h004, 32'h0, `CDP_RESP_SLVERR);
    ex(`CDP_OP_LONG_JUMP, 8'hAB, 16'h0200, 8'h00);
    chk({o_result.length, o_result.target}, {2'h3, 16'hAB00});
    ex(`CDP_OP_SHORT_JUMP, 8'hF0, 16'h1000, 8'h00);
    chk({o_result.length, o_result.target}, {2'h2, 16'h0FF0});
    ex(8'h50, 8'h10, 16'h0100, 8'h00);
    chk({o_result.target_valid, o_result.target}, {1'b1, 16'h0110});
    ex(8'h61, 8'h45, 16'h37FE, 8'h00);
    chk(o_result.target, 32'h3345);
    ex(8'h00, 8'h00, 16'h0001, 8'h00);
    chk(o_result.length, 32'h1);
    ex(`CDP_OP_SET_C, 8'h00, 16'h0002, 8'h00);
    chk(o_result.carry, 32'h1);
    ex(`CDP_OP_MUL, 8'h00, 16'h0003, 8'h20);
    chk({o_result.carry, o_result.overflow}, 32'h1);
    ex(`CDP_OP_CLR_C, 8'h00, 16'h0004, 8'h00);
    chk(o_result.carry, 32'h0);
    ex(`CDP_OP_CJNE_A_IMM, 8'h50, 16'h0007, 8'h40);
    chk(o_result.carry, 32'h1);
    ex(8'h24, 8'h88, 16'h0006, 8'h88);
    chk({o_result.carry, o_result.overflow, o_result.aux_carry}, 32'h7);
    wr(`CDP_ADDR_FLAG_STAT, 8'h00);
    rchk(`CDP_ADDR_FLAG_STAT, 32'hC4, `CDP_RESP_OKAY);
    ex(8'h25, 8'h90, 16'h0008, 8'h00);
    chk({o_result.space, o_result.addr}, {cdp_pkg::CDP_SP_SFR, 8'h90});
    ex(8'h25, 8'h7F, 16'h000A, 8'h00);
    chk({o_result.space, o_result.addr}, {cdp_pkg::CDP_SP_IRAM, 8'h7F});
    ex(8'h2B, 8'h00, 16'h000B, 8'h00);
    chk(o_result.addr, 32'h13);
    ex(8'h27, 8'h00, 16'h000C, 8'h00);
    chk({o_result.indirect, o_result.addr}, 32'h1C5);
    ex(`CDP_OP_MOV_C, 8'h0B, 16'h000D, 8'h00);
    chk({o_result.space, o_result.addr}, {cdp_pkg::CDP_SP_BIT, 8'h21});
    chk(o_result.bit_idx, 32'h3);
    ex(`CDP_OP_LOAD_PTR, 8'h56, 16'h000F, 8'h00);
    ex(`CDP_OP_MOVX_RD, 8'h00, 16'h0010, 8'h00);
    chk(o_result.ext_addr, 32'h5600);
    complete_run;
  end
endmodule

`default_nettype wire
